//--- bench/sleep_ctrl_properties.sv
// Assertions for the sleep mode and reset control block
module sleep_ctrl_properties
  import sleep_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic ext_reset_n_in,
  input wire logic sleep_enable_in,
  input wire logic [2:0] sleep_mode_in,
  input wire logic sleep_req_in,
  input wire logic wake_irq_in,
  input wire logic device_reset_out,
  input wire logic cpu_clk_en_out,
  input wire logic mem_clk_en_out,
  input wire logic timer_clk_en_out,
  input wire logic spi_clk_en_out,
  input wire logic irq_clk_en_out,
  input wire logic async_timer_en_out,
  input wire logic adc_clk_en_out,
  input wire logic osc_en_out,
  input wire logic sleeping_out,
  input wire logic [2:0] active_mode_out,
  input wire logic [PORT_W-1:0] port_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in || !ext_reset_n_in);
  wire logic [7:0] gv = {osc_en_out, adc_clk_en_out, async_timer_en_out, irq_clk_en_out,
    spi_clk_en_out, timer_clk_en_out, mem_clk_en_out, cpu_clk_en_out};
  sequence s_take(m);
    clk_en_in && !device_reset_out && !sleeping_out && sleep_enable_in && sleep_req_in && sleep_mode_in == m;
  endsequence
  sequence s_wake;
    sleeping_out && wake_irq_in && clk_en_in;
  endsequence
  property p_mode(m, g);
    s_take(m) |=> gv == g && sleeping_out && active_mode_out == m;
  endproperty
  a_idle_gates: assert property (p_mode(MODE_IDLE, GATES_IDLE)) else $error("idle gating wrong");
  a_conv_gates: assert property (p_mode(MODE_ADC_NR, GATES_ADC_NR)) else $error("conv gating wrong");
  a_pdown_gates: assert property (p_mode(MODE_PDOWN, GATES_PDOWN)) else $error("pdown gating wrong");
  a_psave_gates: assert property (p_mode(MODE_PSAVE, GATES_PSAVE)) else $error("psave gating wrong");
  a_stdby_gates: assert property (p_mode(MODE_STANDBY, GATES_STANDBY)) else $error("stdby gating wrong");
  a_ext_gates: assert property (p_mode(MODE_EXT_STANDBY, GATES_EXT_STANDBY)) else $error("ext gating wrong");
  a_reset_tristate: assert property (device_reset_out |-> port_oe_out == '0) else $error("pins driven");
  a_refuse_off: assert property (sleep_req_in && !sleep_enable_in && !sleeping_out && clk_en_in |=> !sleeping_out)
    else $error("sleep without enable");
  a_wake_osc: assert property (s_wake |=> osc_en_out && (!cpu_clk_en_out || !sleeping_out))
    else $error("wake start wrong");
  a_wake_bound: assert property (s_wake |-> ##[1:70] !sleeping_out) else $error("no return");
  a_freeze_state: assert property (!clk_en_in |=> $stable(gv) && $stable(sleeping_out) && $stable(port_oe_out))
    else $error("state moved while frozen");
endmodule : sleep_ctrl_properties
bind sleep_ctrl sleep_ctrl_properties i_sleep_ctrl_properties (.*);

//--- bench/sleep_ctrl_tb.sv
// Testbench for the sleep mode and reset control block
module sleep_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sleep_pkg::*;
  logic clock_in, rst_in, clk_en_in, ext_reset_n_in, sleep_enable_in, sleep_req_in, wake_irq_in;
  logic [2:0] sleep_mode_in, active_mode_out;
  logic [PORT_W-1:0] port_data_in, port_oe_in, port_data_out, port_oe_out;
  logic device_reset_out, cpu_clk_en_out, mem_clk_en_out, timer_clk_en_out, spi_clk_en_out;
  logic irq_clk_en_out, async_timer_en_out, adc_clk_en_out, osc_en_out, sleeping_out;
  wire logic [7:0] gv = {osc_en_out, adc_clk_en_out, async_timer_en_out, irq_clk_en_out,
    spi_clk_en_out, timer_clk_en_out, mem_clk_en_out, cpu_clk_en_out};
  int n_fail = 0;
  int n_checks = 0;
  int seed = 42346;
  int waited = 0;
  logic [31:0] held_oe;
  int modes [$] = '{0, 1, 2, 3, 6, 7};
  logic [7:0] gtab [8] = '{8'hFE, 8'hF0, 8'h00, 8'h20, 8'hFF, 8'hFF, 8'h80, 8'hA0};
  sleep_ctrl i_sleep_ctrl (.*);
  initial begin
    clock_in = 0;
    forever #25 clock_in = ~clock_in;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step(input int n = 1);
    repeat (n) @(posedge clock_in);
    #2;
  endtask : step
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic wait_quiet;
    int i;
    for (i = 0; i < 200 && (device_reset_out !== 1'b0 || sleeping_out !== 1'b0); i++) step();
    waited = i;
    if (i == 200) begin
      n_fail++;
      close_out();
    end
  endtask : wait_quiet
  task automatic req(input logic [2:0] m, input logic en);
    logic [31:0] oe;
    logic [31:0] dat;
    oe = $random(seed);
    dat = $random(seed);
    port_oe_in = oe;
    port_data_in = dat;
    sleep_mode_in = m;
    sleep_enable_in = en;
    sleep_req_in = 1;
    step();
    sleep_req_in = 0;
    chk("port oe", port_oe_out, oe);
    chk("port data", port_data_out, dat);
  endtask : req
  initial begin
    rst_in = 1;
    clk_en_in = 1;
    ext_reset_n_in = 1;
    sleep_enable_in = 0;
    sleep_mode_in = 0;
    sleep_req_in = 0;
    wake_irq_in = 0;
    port_data_in = 32'h0000_0000;
    port_oe_in = 32'hFFFF_FFFF;
    #1 chk("oe in reset", port_oe_out, 0);
    step(4);
    rst_in = 0;
    wait_quiet();
    chk("stretch cycles", waited, RST_HOLD_CYC + 3);
    step();
    foreach (modes[k]) begin
      req(modes[k][2:0], 1);
      chk("gates", gv, gtab[modes[k]]);
      chk("mode", active_mode_out, modes[k]);
      step(3);
      chk("held gates", gv, gtab[modes[k]]);
      wake_irq_in = 1;
      step();
      wake_irq_in = 0;
      chk("cpu in start", cpu_clk_en_out, 0);
      chk("osc at wake", osc_en_out, 1);
      wait_quiet();
      chk("start cycles", waited, gtab[modes[k]][G_OSC] ? OSC_START_FAST_CYC : OSC_START_SLOW_CYC);
      chk("awake gates", gv, 8'hFF);
      $display("test mode %0d done", modes[k]);
    end
    req(3'h4, 1);
    chk("bad mode", sleeping_out, 0);
    step();
    req(3'h2, 0);
    chk("no enable", sleeping_out, 0);
    $display("test refusal done");
    step();
    held_oe = port_oe_out;
    clk_en_in = 0;
    port_oe_in = ~held_oe;
    sleep_mode_in = 3'h2;
    sleep_enable_in = 1;
    sleep_req_in = 1;
    step(3);
    chk("frozen sleep", sleeping_out, 0);
    chk("frozen gates", gv, 8'hFF);
    chk("frozen oe", port_oe_out, held_oe);
    sleep_req_in = 0;
    clk_en_in = 1;
    step();
    chk("thawed sleep", sleeping_out, 0);
    chk("thawed oe", port_oe_out, ~held_oe);
    $display("test clock enable done");
    req(3'h2, 1);
    ext_reset_n_in = 0;
    #1 chk("pin reset oe", port_oe_out, 0);
    chk("pin reset", device_reset_out, 1);
    chk("pin reset gates", gv, 8'hFF);
    chk("pin reset data", port_data_out, 0);
    step();
    ext_reset_n_in = 1;
    wait_quiet();
    chk("pin stretch cycles", waited, RST_HOLD_CYC + 3);
    $display("test pin reset done");
    close_out();
  end
endmodule : sleep_ctrl_tb

//--- hdl/reset_stretch.sv
// Reset combiner and release stretcher
module reset_stretch
  import sleep_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic ext_reset_n_in,
  output logic hold_out
);

  logic arst;
  logic sync1_r;
  logic sync2_r;
  logic [7:0] cnt_r;

  // Pin low asserts at once, no clock needed
  assign arst = rst_in | ~ext_reset_n_in;

  ////////////////////////////////////////////////////////////////
  // Release synchroniser
  always_ff @(posedge clock_in or posedge arst) begin
    if (arst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else if (clk_en_in) begin
      sync1_r <= 1'b1;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Hold counter
  always_ff @(posedge clock_in or posedge arst) begin
    if (arst) begin
      cnt_r <= 8'h00;
      hold_out <= 1'b1;
    end else if (clk_en_in && sync2_r) begin
      if (cnt_r != RST_HOLD_CNT) begin
        cnt_r <= cnt_r + 8'h01;
      end else begin
        hold_out <= 1'b0;
      end
    end
  end

endmodule : reset_stretch

//--- hdl/sleep_ctrl.sv
// Sleep mode sequencer, clock gating and reset pin release
module sleep_ctrl
  import sleep_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic ext_reset_n_in,
  input wire logic sleep_enable_in,
  input wire logic [2:0] sleep_mode_in,
  input wire logic sleep_req_in,
  input wire logic wake_irq_in,
  input wire logic [PORT_W-1:0] port_data_in,
  input wire logic [PORT_W-1:0] port_oe_in,
  output logic device_reset_out,
  output logic cpu_clk_en_out,
  output logic mem_clk_en_out,
  output logic timer_clk_en_out,
  output logic spi_clk_en_out,
  output logic irq_clk_en_out,
  output logic async_timer_en_out,
  output logic adc_clk_en_out,
  output logic osc_en_out,
  output logic sleeping_out,
  output logic [2:0] active_mode_out,
  output logic [PORT_W-1:0] port_data_out,
  output logic [PORT_W-1:0] port_oe_out
);

  pwr_state_e state_r;
  pwr_state_e state_nxt;
  logic hold;
  logic [7:0] start_cnt_r;
  logic [7:0] start_cnt_nxt;
  logic [2:0] mode_r;
  logic [GATE_W-1:0] gates_r;
  logic [GATE_W-1:0] gates_nxt;
  logic sleep_take;

  ////////////////////////////////////////////////////////////////
  // Mode decode
  function automatic logic mode_valid(input logic [2:0] m);
    case (m)
      MODE_IDLE, MODE_ADC_NR, MODE_PDOWN, MODE_PSAVE, MODE_STANDBY, MODE_EXT_STANDBY: begin
        mode_valid = 1'b1;
      end
      default: begin
        mode_valid = 1'b0;
      end
    endcase
  endfunction : mode_valid

  function automatic logic [GATE_W-1:0] mode_gates(input logic [2:0] m);
    case (m)
      MODE_IDLE: begin
        mode_gates = GATES_IDLE;
      end
      MODE_ADC_NR: begin
        mode_gates = GATES_ADC_NR;
      end
      MODE_PDOWN: begin
        mode_gates = GATES_PDOWN;
      end
      MODE_PSAVE: begin
        mode_gates = GATES_PSAVE;
      end
      MODE_STANDBY: begin
        mode_gates = GATES_STANDBY;
      end
      MODE_EXT_STANDBY: begin
        mode_gates = GATES_EXT_STANDBY;
      end
      default: begin
        mode_gates = GATES_ACTIVE;
      end
    endcase
  endfunction : mode_gates

  function automatic logic [7:0] start_count(input logic osc_on);
    if (osc_on) begin
      start_count = START_FAST_CNT;
    end else begin
      start_count = START_SLOW_CNT;
    end
  endfunction : start_count

  ////////////////////////////////////////////////////////////////
  // Reset combiner
  reset_stretch i_reset_stretch (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .ext_reset_n_in(ext_reset_n_in),
    .hold_out(hold)
  );

  assign device_reset_out = hold;

  ////////////////////////////////////////////////////////////////
  // Sequencer
  assign sleep_take = sleep_req_in && sleep_enable_in && mode_valid(sleep_mode_in);

  always_comb begin
    state_nxt = state_r;
    start_cnt_nxt = start_cnt_r;
    gates_nxt = gates_r;
    case (state_r)
      ST_ACTIVE: begin
        if (sleep_take) begin
          state_nxt = ST_SLEEP;
          gates_nxt = mode_gates(sleep_mode_in);
        end
      end
      ST_SLEEP: begin
        if (wake_irq_in) begin
          state_nxt = ST_START;
          gates_nxt[G_OSC] = 1'b1;
          start_cnt_nxt = start_count(gates_r[G_OSC]);
        end
      end
      ST_START: begin
        if (start_cnt_r <= 8'h01) begin
          state_nxt = ST_ACTIVE;
          gates_nxt = GATES_ACTIVE;
          start_cnt_nxt = 8'h00;
        end else begin
          start_cnt_nxt = start_cnt_r - 8'h01;
        end
      end
      default: begin
        state_nxt = ST_ACTIVE;
        gates_nxt = GATES_ACTIVE;
        start_cnt_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge hold) begin
    if (hold) begin
      state_r <= ST_ACTIVE;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Oscillator start counter
  always_ff @(posedge clock_in or posedge hold) begin
    if (hold) begin
      start_cnt_r <= 8'h00;
    end else if (clk_en_in) begin
      start_cnt_r <= start_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Gate vector of the current mode
  always_ff @(posedge clock_in or posedge hold) begin
    if (hold) begin
      gates_r <= GATES_ACTIVE;
    end else if (clk_en_in) begin
      gates_r <= gates_nxt;
    end
  end

  always_ff @(posedge clock_in or posedge hold) begin
    if (hold) begin
      mode_r <= MODE_RST;
    end else if (clk_en_in && state_r == ST_ACTIVE && sleep_take) begin
      mode_r <= sleep_mode_in;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Registered gate outputs
  always_ff @(posedge clock_in or posedge hold) begin
    if (hold) begin
      cpu_clk_en_out <= 1'b1;
      mem_clk_en_out <= 1'b1;
      timer_clk_en_out <= 1'b1;
      spi_clk_en_out <= 1'b1;
      irq_clk_en_out <= 1'b1;
      async_timer_en_out <= 1'b1;
      adc_clk_en_out <= 1'b1;
      osc_en_out <= 1'b1;
    end else if (clk_en_in) begin
      cpu_clk_en_out <= gates_nxt[G_CPU] && state_nxt == ST_ACTIVE;
      mem_clk_en_out <= gates_nxt[G_MEM];
      timer_clk_en_out <= gates_nxt[G_TIMER];
      spi_clk_en_out <= gates_nxt[G_SPI];
      irq_clk_en_out <= gates_nxt[G_IRQ];
      async_timer_en_out <= gates_nxt[G_ASYNC];
      adc_clk_en_out <= gates_nxt[G_ADC];
      osc_en_out <= gates_nxt[G_OSC];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Registered status outputs
  always_ff @(posedge clock_in or posedge hold) begin
    if (hold) begin
      sleeping_out <= 1'b0;
      active_mode_out <= MODE_RST;
    end else if (clk_en_in) begin
      sleeping_out <= state_nxt != ST_ACTIVE;
      active_mode_out <= (state_r == ST_ACTIVE && sleep_take) ? sleep_mode_in : mode_r;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Port pins, released while any reset is active
  always_ff @(posedge clock_in or posedge hold) begin
    if (hold) begin
      port_oe_out <= PORT_OE_RST;
    end else if (clk_en_in) begin
      port_oe_out <= port_oe_in;
    end
  end

  always_ff @(posedge clock_in or posedge hold) begin
    if (hold) begin
      port_data_out <= PORT_DATA_RST;
    end else if (clk_en_in) begin
      port_data_out <= port_data_in;
    end
  end

endmodule : sleep_ctrl

//--- hdl/sleep_pkg.sv
// Constants for the sleep mode and reset control block
// Function
// - Six software selectable sleep modes, each with its own gating of clocks.
// - Idle halts the CPU; memory, timers, SPI and interrupts keep running.
// - Power-down keeps registers, stops oscillator; only interrupt or reset wakes.
// - Power-save is power-down with the asynchronous timer still running.
// - Converter noise reduction halts CPU and I/O except interrupts, async timer and converter.
// - Standby keeps the main oscillator running, everything else sleeps.
// - Extended standby keeps main oscillator and asynchronous timer running.
// - Any active reset tristates all port pins, even with no clock.
// - Low reset input resets the device without a clock; short pulses may not.
package sleep_pkg;

  localparam int PORT_W = 32;
  localparam int GATE_W = 8;

  // Sleep mode select codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADC_NR = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

  // Gate vector bit positions
  localparam int G_CPU = 0;
  localparam int G_MEM = 1;
  localparam int G_TIMER = 2;
  localparam int G_SPI = 3;
  localparam int G_IRQ = 4;
  localparam int G_ASYNC = 5;
  localparam int G_ADC = 6;
  localparam int G_OSC = 7;

  // Gate vectors per mode, bit order osc adc async irq spi timer mem cpu
  localparam logic [7:0] GATES_ACTIVE = 8'hFF;
  localparam logic [7:0] GATES_IDLE = 8'hFE;
  localparam logic [7:0] GATES_ADC_NR = 8'hF0;
  localparam logic [7:0] GATES_PDOWN = 8'h00;
  localparam logic [7:0] GATES_PSAVE = 8'h20;
  localparam logic [7:0] GATES_STANDBY = 8'h80;
  localparam logic [7:0] GATES_EXT_STANDBY = 8'hA0;

  // Reset values
  localparam logic [PORT_W-1:0] PORT_OE_RST = 32'h0000_0000;
  localparam logic [PORT_W-1:0] PORT_DATA_RST = 32'h0000_0000;
  localparam logic [2:0] MODE_RST = 3'h0;

  // Timing counts in clock cycles
  localparam int RST_HOLD_CYC = 16;
  localparam int OSC_START_SLOW_CYC = 64;
  localparam int OSC_START_FAST_CYC = 6;
  localparam logic [7:0] RST_HOLD_CNT = 8'(RST_HOLD_CYC);
  localparam logic [7:0] START_SLOW_CNT = 8'(OSC_START_SLOW_CYC);
  localparam logic [7:0] START_FAST_CNT = 8'(OSC_START_FAST_CYC);

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_SLEEP = 2'b01,
    ST_START = 2'b10
  } pwr_state_e;

endpackage : sleep_pkg
